// >>> src/diag_log.sv
// diagnostic logs and Phy event counters, read as byte windows over APB
// assumes event strobes are one-cycle pulses from logic on pclk
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module diag_log
    import diag_log_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        st_done,
    input  wire logic [7:0]  st_number,
    input  wire logic [7:0]  st_status,
    input  wire logic [15:0] st_hours,
    input  wire logic [7:0]  st_checkpoint,
    input  wire logic [47:0] st_fail_lba,
    input  wire logic        err_valid,
    input  wire logic        err_icrc,
    input  wire logic        non_queued_flag,
    input  wire logic [4:0]  err_tag,
    input  wire logic [7:0]  err_status,
    input  wire logic [7:0]  err_error,
    input  wire logic [23:0] err_lba,
    input  wire logic [7:0]  err_device,
    input  wire logic [23:0] err_lba_prev,
    input  wire logic [7:0]  err_count,
    input  wire logic [7:0]  err_count_prev,
    input  wire logic        link_ready,
    input  wire logic        sig_fis_tx,
    input  wire logic        rx_fis_crc_err,
    input  wire logic        rx_fis_other_err,
    input  wire logic        bist_activate_rx
);
    logic [87:0]      st_mem [ST_ENTRIES];
    logic [7:0]       st_sum [ST_ENTRIES];
    logic [4:0]       st_idx_reg;
    logic             st_any_reg;
    logic [4:0]       st_slot;
    logic [87:0]      st_new;
    logic [7:0]       st_new_sum;
    logic [7:0]       st_cksum;
    logic [111:0]     ce_reg;
    logic             ce_valid_reg;
    logic [7:0]       ce_sum;
    logic [CNT_W-1:0] cnt     [CNT_N];
    logic [CNT_W-1:0] snap_reg [CNT_N];
    logic [CNT_N-1:0] cnt_inc;
    logic [159:0]     phy_body;
    logic [7:0]       phy_sum;
    logic             link_ready_prev;
    logic             cnt_clr;
    logic [7:0]       page_reg;
    logic             feat_reg;
    logic             access;
    logic             wr_cmd;
    logic [31:0]      rd_word;
    logic             rd_err;

    // identifiers in page order with the size code in bits 14:12
    function automatic logic [15:0] cnt_id(input int k);
        logic [11:0] code;
        code = ID_ICRC;
        unique case (k)
            0: code = ID_ICRC;
            1: code = ID_RDY_DROP;
            2: code = ID_SIG_TX;
            3: code = ID_RX_CRC;
            default: code = ID_RX_OTHER;
        endcase
        return {1'b0, CNT_SIZE, code};
    endfunction

    // ---------------- self-test descriptor ring
    assign st_new = {st_fail_lba, st_checkpoint, st_hours, st_status, st_number};
    // first test lands in slot 0; slot 17 wraps, so test 19 overwrites entry 1
    // and the last slot stays empty
    assign st_slot = !st_any_reg ? 5'h00 :
                     (st_idx_reg == ST_IDX_MAX - 5'h01) ? 5'h00 : st_idx_reg + 5'h01;

    byte_sum #(.N(11)) u_st_sum (
        .data (st_new),
        .sum  (st_new_sum)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ST_ENTRIES; i++) begin
                st_mem[i] <= '0;
                st_sum[i] <= 8'h00;
            end
        end else if (st_done) begin
            st_mem[st_slot] <= st_new;
            st_sum[st_slot] <= st_new_sum;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_idx_reg <= 5'h00;
            st_any_reg <= 1'b0;
        end else if (st_done) begin
            st_idx_reg <= st_slot;
            st_any_reg <= 1'b1;
        end
    end

    always_comb begin
        st_cksum = ST_REV + {3'b000, st_idx_reg};
        for (int i = 0; i < ST_ENTRIES; i++) begin
            st_cksum = st_cksum + st_sum[i];
        end
        st_cksum = 8'h00 - st_cksum;
    end

    // ---------------- command error snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_reg       <= '0;
            ce_valid_reg <= 1'b0;
        end else if (err_valid) begin
            // tag kept as given; meaningless when non_queued_flag is set
            ce_reg <= {err_count_prev, err_count, 8'h00, err_lba_prev,
                       err_device, err_lba, err_error, err_status, 8'h00,
                       non_queued_flag, 2'b00, err_tag};
            ce_valid_reg <= 1'b1;
        end
    end

    byte_sum #(.N(14)) u_ce_sum (
        .data (ce_reg),
        .sum  (ce_sum)
    );

    // ---------------- Phy event counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_ready_prev <= 1'b0;
        end else begin
            link_ready_prev <= link_ready;
        end
    end

    assign access  = psel && penable && pready;
    assign wr_cmd  = access && pwrite && paddr == ADDR_CMD;
    assign cnt_clr = bist_activate_rx ||
                     (wr_cmd && pwdata[7:0] == PAGE_PHY && pwdata[CMD_FEAT_BIT]);

    // received = from host, transmitted = to host
    assign cnt_inc[0] = err_valid && err_icrc;
    assign cnt_inc[1] = link_ready_prev && !link_ready;
    assign cnt_inc[2] = sig_fis_tx;
    assign cnt_inc[3] = rx_fis_crc_err;
    assign cnt_inc[4] = rx_fis_other_err;

    // no reset input other than presetn reaches the counters
    for (genvar g = 0; g < CNT_N; g++) begin : g_cnt
        sat_counter #(.W(CNT_W)) u_cnt (
            .pclk    (pclk),
            .presetn (presetn),
            .clr     (cnt_clr),
            .inc     (cnt_inc[g]),
            .count   (cnt[g])
        );
        assign phy_body[g*32 +: 32] = {snap_reg[g], cnt_id(g)};
    end

    // snapshot taken on the same edge that clears, so it holds pre-clear values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CNT_N; i++) begin
                snap_reg[i] <= '0;
            end
        end else if (wr_cmd && pwdata[7:0] == PAGE_PHY) begin
            for (int i = 0; i < CNT_N; i++) begin
                snap_reg[i] <= cnt[i];
            end
        end
    end

    byte_sum #(.N(20)) u_phy_sum (
        .data (phy_body),
        .sum  (phy_sum)
    );

    // ---------------- page byte view
    function automatic logic [7:0] page_byte(input logic [8:0] b);
        logic [8:0] rel;
        logic [4:0] ent;
        logic [8:0] off;
        logic [7:0] v;
        rel = b - ST_FIRST;
        ent = 5'(rel / ST_DESC_BYTES);
        off = rel % ST_DESC_BYTES;
        v   = 8'h00;
        unique case (page_reg)
            PAGE_SELFTEST: begin
                if (b == 9'h000) begin
                    v = ST_REV;
                end else if (b == BYTE_IDX) begin
                    v = {3'b000, st_idx_reg};
                end else if (b >= ST_FIRST && b < ST_END && off < ST_FIELD_BYTES) begin
                    v = st_mem[ent][off*8 +: 8];
                end else if (b == BYTE_CKSUM) begin
                    v = st_cksum;
                end
            end
            PAGE_CMD_ERR: begin
                if (b <= CE_LAST) begin
                    v = ce_reg[b*8 +: 8];
                end else if (b == BYTE_CKSUM) begin
                    v = 8'h00 - ce_sum;
                end
            end
            PAGE_PHY: begin
                // bytes 0-3, terminator 24-25 and reserved bytes read zero
                if (b >= PHY_FIRST && b < PHY_TERM) begin
                    v = phy_body[(b - PHY_FIRST)*8 +: 8];
                end else if (b == BYTE_CKSUM) begin
                    v = 8'h00 - phy_sum;
                end
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ---------------- APB slave
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (paddr <= ADDR_WIN_LAST) begin
            if (!pwrite) begin
                for (int k = 0; k < 4; k++) begin
                    rd_word[k*8 +: 8] = page_byte({paddr[8:2], 2'(k)});
                end
            end
        end else if (paddr == ADDR_CMD) begin
            rd_word = {23'h000000, feat_reg, page_reg};
        end else if (paddr == ADDR_STAT) begin
            rd_word = {22'h000000, ce_valid_reg, st_any_reg, 3'b000, st_idx_reg};
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_reg <= PAGE_SELFTEST;
            feat_reg <= 1'b0;
        end else if (wr_cmd) begin
            page_reg <= pwdata[7:0];
            feat_reg <= pwdata[CMD_FEAT_BIT];
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= rd_err;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    a_idx_range: assert property (@(posedge pclk) disable iff (!presetn)
        st_idx_reg <= ST_IDX_MAX)
        else $error("descriptor index out of range");
    a_ring_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (st_done && st_any_reg && st_idx_reg == ST_IDX_MAX - 5'h01) |=> st_idx_reg == 5'h00)
        else $error("descriptor ring did not wrap");
    a_err_capture: assert property (@(posedge pclk) disable iff (!presetn)
        err_valid |=> ce_reg[CE_NQ_BIT] == $past(non_queued_flag)
                      && ce_reg[4:0] == $past(err_tag) && ce_reg[6:5] == 2'b00)
        else $error("error byte 0 not captured");
    a_err_count: assert property (@(posedge pclk) disable iff (!presetn)
        (err_valid && err_icrc && !cnt_clr && cnt[0] != 16'hFFFF)
        |=> cnt[0] == $past(cnt[0]) + 16'h0001 && ce_valid_reg)
        else $error("crc failure not counted with snapshot");
    a_rdy_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (link_ready_prev && !link_ready && !cnt_clr && cnt[1] != 16'hFFFF)
        |=> cnt[1] == $past(cnt[1]) + 16'h0001)
        else $error("link drop not counted");
    a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && pwdata[7:0] == PAGE_PHY && pwdata[CMD_FEAT_BIT] && !cnt_inc[2])
        |=> snap_reg[2] == $past(cnt[2]) && cnt[2] == 16'h0000)
        else $error("read-and-clear lost values");
    a_bist_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (bist_activate_rx && !cnt_inc[3]) |=> cnt[3] == 16'h0000)
        else $error("bist activate did not clear");
    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    a_apb_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready)
        else $error("answer without a select");
    a_cmd_page: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd |=> page_reg == $past(pwdata[7:0]) && feat_reg == $past(pwdata[CMD_FEAT_BIT]))
        else $error("command register not written");

    a_sig_count: assert property (@(posedge pclk) disable iff (!presetn)
        (sig_fis_tx && !cnt_clr && cnt[2] != 16'hFFFF) |=> cnt[2] == $past(cnt[2]) + 16'h0001)
        else $error("signature send not counted");
    a_rx_crc_count: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_fis_crc_err && !cnt_clr && cnt[3] != 16'hFFFF) |=> cnt[3] == $past(cnt[3]) + 16'h0001)
        else $error("received crc error not counted");
    a_rx_other_count: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_fis_other_err && !cnt_clr && cnt[4] != 16'hFFFF)
        |=> cnt[4] == $past(cnt[4]) + 16'h0001)
        else $error("received other error not counted");
    a_counts_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (!cnt_clr && cnt_inc == '0) |=> cnt[0] == $past(cnt[0]) && cnt[1] == $past(cnt[1])
        && cnt[2] == $past(cnt[2]) && cnt[3] == $past(cnt[3]) && cnt[4] == $past(cnt[4]))
        else $error("counter changed without an event");
    a_bist_all: assert property (@(posedge pclk) disable iff (!presetn)
        (bist_activate_rx && cnt_inc == '0) |=> cnt[0] == 16'h0000 && cnt[1] == 16'h0000
        && cnt[2] == 16'h0000 && cnt[3] == 16'h0000 && cnt[4] == 16'h0000)
        else $error("bist activate left a counter set");
    a_snap_take: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_cmd && pwdata[7:0] == PAGE_PHY)
        |=> snap_reg[0] == $past(cnt[0]) && snap_reg[4] == $past(cnt[4]))
        else $error("counter snapshot not taken");
    a_slot_write: assert property (@(posedge pclk) disable iff (!presetn)
        st_done |=> st_mem[st_idx_reg] == $past(st_new) && st_any_reg)
        else $error("self-test descriptor not stored");
    a_idx_none: assert property (@(posedge pclk) disable iff (!presetn)
        !st_any_reg |-> st_idx_reg == 5'h00)
        else $error("descriptor index set with no self-test");
    a_ring_first: assert property (@(posedge pclk) disable iff (!presetn)
        (st_done && !st_any_reg) |=> st_idx_reg == 5'h00)
        else $error("first self-test not in entry one");
    a_ce_regs: assert property (@(posedge pclk) disable iff (!presetn)
        err_valid |=> ce_reg[23:16] == $past(err_status) && ce_reg[31:24] == $past(err_error)
                      && ce_reg[103:96] == $past(err_count))
        else $error("shadow registers not captured");
endmodule

// >>> src/diag_log_pkg.sv
// constants shared by the diagnostic log block and its helpers
// assumes a single 100 MHz device clock and 32-bit APB register access
//
// Overview of operation
// - byte 0 of every extended self-test log sector reads revision 01h.
// - descriptor index names the most recent entry, zero if none, range 0..18; this design's index stays within 0..17.
// - each descriptor is 26 bytes: number, status, hours, checkpoint, LBA, vendor.
// - command error byte 0: tag in bits 4-0, non-queued in bit 7, 6-5 zero.
// - with non-queued clear the data belongs to the tagged queued command.
// - command error bytes 1-13 snapshot the shadow registers at error time.
// - byte 511 of error and counter pages makes the 512-byte sum zero.
// - counters reset at power-up, surviving link and software resets.
// - a received BIST Activate FIS clears every Phy event counter.
// - page 11h read with feature bit 0 returns values, then clears counters.
// - each counter entry starts with a 16-bit identifier giving its size.
// - size code 1h,2h,3h,4h means 16,32,48,64-bit values.
// - identifier 001h counts commands failed by interface CRC error.
// - identifier 009h counts link-ready to link-not-ready transitions.
// - identifier 00Ah counts signature register FISes sent after link reset.
// - 00Bh counts received FISes with CRC error, 00Dh other errors.
// - identifier 000h carries no value and ends the counter list.
// - counter page: zeros 0-3, five pairs from byte 4, terminator 24-25.
// - transmitted means device to host, received means host to device.
// - descriptors form a ring; test 19 overwrites entry 1; unused entries read zero.
package diag_log_pkg;
    localparam logic [7:0]  PAGE_SELFTEST = 8'h07;
    localparam logic [7:0]  PAGE_CMD_ERR  = 8'h10;
    localparam logic [7:0]  PAGE_PHY      = 8'h11;
    localparam int          CMD_FEAT_BIT  = 8;
    localparam logic [11:0] ADDR_WIN_LAST = 12'h1FC;
    localparam logic [11:0] ADDR_CMD      = 12'h200;
    localparam logic [11:0] ADDR_STAT     = 12'h204;
    localparam logic [7:0]  ST_REV        = 8'h01;
    localparam int          ST_ENTRIES    = 19;
    localparam logic [4:0]  ST_IDX_MAX    = 5'h12;
    localparam logic [8:0]  ST_FIRST      = 9'h004;
    localparam logic [8:0]  ST_DESC_BYTES = 9'h01A;
    localparam logic [8:0]  ST_FIELD_BYTES = 9'h00B;
    localparam logic [8:0]  ST_END        = 9'h1F2;
    localparam logic [8:0]  BYTE_IDX      = 9'h002;
    localparam logic [8:0]  BYTE_CKSUM    = 9'h1FF;
    localparam logic [8:0]  CE_LAST       = 9'h00D;
    localparam int          CE_NQ_BIT     = 7;
    localparam logic [8:0]  PHY_FIRST     = 9'h004;
    localparam logic [8:0]  PHY_TERM      = 9'h018;
    localparam int          CNT_N         = 5;
    localparam int          CNT_W         = 16;
    localparam logic [2:0]  CNT_SIZE      = 3'h1;
    localparam logic [11:0] ID_ICRC       = 12'h001;
    localparam logic [11:0] ID_RDY_DROP   = 12'h009;
    localparam logic [11:0] ID_SIG_TX     = 12'h00A;
    localparam logic [11:0] ID_RX_CRC     = 12'h00B;
    localparam logic [11:0] ID_RX_OTHER   = 12'h00D;
endpackage

// >>> src/sat_counter.sv
// saturating event counter with synchronous clear
// assumes inc and clr come from logic on the same clock
`timescale 1ns/1ns
module sat_counter #(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clr,
    input  wire logic         inc,
    output logic [W-1:0]      count
);
    // clear and a same-cycle event leave a count of one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clr) begin
            count <= {{(W-1){1'b0}}, inc};
        end else if (inc && count != {W{1'b1}}) begin
            count <= count + 1'b1;
        end
    end

    a_count_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (inc && !clr && count == {W{1'b1}}) |=> count == {W{1'b1}})
        else $error("counter wrapped past its maximum");
    a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (clr && !inc) |=> count == '0)
        else $error("counter not cleared");
endmodule

// >>> src/byte_sum.sv
// modulo-256 sum of a packed group of bytes
// assumes byte k sits in bits 8k+7..8k
`timescale 1ns/1ns
module byte_sum #(
    parameter int N = 4
) (
    input  wire logic [N*8-1:0] data,
    output logic [7:0]          sum
);
    always_comb begin
        sum = 8'h00;
        for (int k = 0; k < N; k++) begin
            sum = sum + data[k*8 +: 8];
        end
    end
endmodule

// >>> verif/host_link_model.sv
// host side of the link: signature sends, received FIS errors, link drops, BIST
// assumes send() is called right after a rising edge of pclk
`timescale 1ns/1ns
module host_link_model (
    input  wire logic pclk,
    output logic      link_ready,
    output logic      sig_fis_tx,
    output logic      rx_fis_crc_err,
    output logic      rx_fis_other_err,
    output logic      bist_activate_rx
);
    initial begin
        {link_ready, sig_fis_tx, rx_fis_crc_err, rx_fis_other_err, bist_activate_rx} = 5'b10000;
    end

    // kind 0 link drop, 1 signature sent, 2 rx crc, 3 rx other, 4 bist
    // hold keeps the event asserted for all n cycles
    task automatic send(input int kind, input int n, input logic hold);
        for (int i = 0; i < n; i++) begin
            case (kind)
                0: link_ready <= 1'b0;
                1: sig_fis_tx <= 1'b1;
                2: rx_fis_crc_err <= 1'b1;
                3: rx_fis_other_err <= 1'b1;
                default: bist_activate_rx <= 1'b1;
            endcase
            @(posedge pclk);
            if (!hold || i == n - 1) begin
                {link_ready, sig_fis_tx, rx_fis_crc_err, rx_fis_other_err,
                 bist_activate_rx} <= 5'b10000;
                @(posedge pclk);
            end
        end
    endtask
endmodule

// >>> verif/sata_diag_log_and_phy_counters_tb.sv
// self-checking bench for the diagnostic log block over APB
// assumes the design package and the host link model are compiled first
`timescale 1ns/1ns
module sata_diag_log_and_phy_counters_tb
    import diag_log_pkg::*;
;
    localparam logic [87:0] EPAT = 88'h5184_332211_E0_665544_0708;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        st_done, err_valid, err_icrc, non_queued_flag;
    logic [7:0]  st_number, st_status, st_checkpoint, err_status, err_error;
    logic [7:0]  err_device, err_count, err_count_prev;
    logic [15:0] st_hours;
    logic [47:0] st_fail_lba;
    logic [4:0]  err_tag;
    logic [23:0] err_lba, err_lba_prev;
    logic        link_ready, sig_fis_tx, rx_fis_crc_err, rx_fis_other_err, bist_activate_rx;
    int          fails = 0;
    int          total_checks = 0;

    always #5 pclk = ~pclk;

    diag_log i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .st_done, .st_number, .st_status, .st_hours, .st_checkpoint,
        .st_fail_lba, .err_valid, .err_icrc, .non_queued_flag, .err_tag, .err_status,
        .err_error, .err_lba, .err_device, .err_lba_prev, .err_count, .err_count_prev,
        .link_ready, .sig_fis_tx, .rx_fis_crc_err, .rx_fis_other_err, .bist_activate_rx
    );

    host_link_model i_host (
        .pclk, .link_ready, .sig_fis_tx, .rx_fis_crc_err, .rx_fis_other_err,
        .bist_activate_rx
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic hard_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    // one transfer; waits for pready, then releases and lets an edge pass
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        {rdat, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask

    task automatic rw(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("word %h", a), rdat, e);
    endtask

    task automatic page_sum(input logic [7:0] pg);
        logic [7:0] s;
        s = 8'h00;
        apb(1'b1, ADDR_CMD, {24'h0, pg});
        for (int w = 0; w < 128; w++) begin
            apb(1'b0, 12'(w * 4), 32'h0);
            s = s + rdat[7:0] + rdat[15:8] + rdat[23:16] + rdat[31:24];
        end
        chk("page sum", {24'h0, s}, 32'h0);
    endtask

    task automatic self_test(input logic [7:0] k);
        {st_number, st_status, st_hours, st_checkpoint, st_fail_lba} <=
            {k, k ^ 8'h20, k, 8'hA5, ~k, 40'hC0FFEE1234, k};
        st_done <= 1'b1;
        @(posedge pclk);
        st_done <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic desc_chk(input logic [11:0] a, input logic [7:0] k);
        rw(a, {k, 8'hA5, k ^ 8'h20, k});
        rw(a + 12'h004, {8'h12, 8'h34, k, ~k});
        rw(a + 12'h008, 32'h00C0FFEE);
    endtask

    task automatic ce_chk(input logic nq, input logic [4:0] t, input logic ic);
        logic [87:0] f;
        f = EPAT ^ {11{3'h0, t}};
        {err_valid, err_icrc, non_queued_flag, err_tag} <= {1'b1, ic, nq, t};
        {err_status, err_error, err_lba, err_device, err_lba_prev, err_count,
         err_count_prev} <= f;
        @(posedge pclk);
        err_valid <= 1'b0;
        @(posedge pclk);
        apb(1'b1, ADDR_CMD, {24'h0, PAGE_CMD_ERR});
        rw(12'h000, {f[79:72], f[87:80], 8'h00, nq, 2'b00, t});
        rw(12'h004, {f[47:40], f[71:48]});
        rw(12'h008, {8'h00, f[39:16]});
        rw(12'h00C, {16'h0000, f[7:0], f[15:8]});
        page_sum(PAGE_CMD_ERR);
    endtask

    task automatic phy_chk(input logic [15:0] c1, c9, ca, cb, cd);
        apb(1'b1, ADDR_CMD, {24'h0, PAGE_PHY});
        rw(12'h000, 32'h0);
        rw(12'h004, {c1, 16'h1001});
        rw(12'h008, {c9, 16'h1009});
        rw(12'h00C, {ca, 16'h100A});
        rw(12'h010, {cb, 16'h100B});
        rw(12'h014, {cd, 16'h100D});
        rw(12'h018, 32'h0);
    endtask

    initial begin
        repeat (80000) @(posedge pclk);
        fails++;
        $display("ERROR watchdog expired");
        conclude();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {st_done, st_number, st_status, st_hours, st_checkpoint, st_fail_lba} = '0;
        {err_valid, err_icrc, non_queued_flag, err_tag, err_status, err_error} = '0;
        {err_lba, err_device, err_lba_prev, err_count, err_count_prev} = '0;
        hard_reset();
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat", rdat, 32'h0);
        apb(1'b0, 12'h208, 32'h0);
        chk("unmapped slverr", {31'h0, rerr}, 32'h1);
        apb(1'b1, ADDR_CMD, {24'h0, PAGE_SELFTEST});
        rw(12'h000, 32'h0000_0001);
        rw(12'h004, 32'h0);
        for (int k = 1; k <= 21; k++) begin
            self_test(8'(k));
            if (k == 1) rw(12'h020, 32'h0);
            if (k == 19) rw(12'h1D8, 32'h0);
            if (k == 1 || k == 17 || k == 19 || k == 21) begin
                rw(12'h000, {8'h00, 8'(k == 17 ? 16 : k == 21 ? 2 : 0), 16'h0001});
                desc_chk(k == 17 ? 12'h1A4 : k == 21 ? 12'h038 : 12'h004, 8'(k));
            end
        end
        page_sum(PAGE_SELFTEST);
        ce_chk(1'b0, 5'h15, 1'b1);
        ce_chk(1'b1, 5'h0A, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("stat", rdat, 32'h0000_0302);
        i_host.send(0, 2, 1'b0);
        i_host.send(1, 3, 1'b0);
        i_host.send(2, 4, 1'b0);
        i_host.send(3, 5, 1'b1);
        phy_chk(16'h1, 16'h2, 16'h3, 16'h4, 16'h5);
        page_sum(PAGE_PHY);
        apb(1'b1, ADDR_CMD, {23'h0, 1'b1, PAGE_PHY});
        rw(12'h010, {16'h0004, 16'h100B});
        phy_chk(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        i_host.send(1, 2, 1'b0);
        ce_chk(1'b1, 5'h03, 1'b1);
        phy_chk(16'h1, 16'h0, 16'h2, 16'h0, 16'h0);
        i_host.send(4, 1, 1'b0);
        phy_chk(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        i_host.send(2, 65537, 1'b1);
        phy_chk(16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0);
        hard_reset();
        phy_chk(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        conclude();
    end
endmodule
